//--- logic/mecs_defines.svh
`ifndef MECS_DEFINES_SVH
`define MECS_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MECS_OFS_PULSE_FIFO 8'hb1
`define MECS_OFS_SMOOTH 8'hb2
`define MECS_OFS_SLEEP_RPT 8'hb3
`define MECS_OFS_CONTROL 8'hbc
// ----------------------------------------
// Field positions
// ----------------------------------------
`define MECS_LVL_HI 7
`define MECS_LVL_LO 6
`define MECS_PULSE_HI 5
`define MECS_PULSE_LO 0
`define MECS_SM_LEN_BIT 5
`define MECS_SM_EN_BIT 4
`define MECS_SLEEP_BIT 1
`define MECS_CLR_BIT 0
// ----------------------------------------
// Reset values and level counts
// ----------------------------------------
`define MECS_RST_PULSE_FIFO 8'h00
`define MECS_RST_SMOOTH 8'h00
`define MECS_LVL0 6'h01
`define MECS_LVL1 6'h04
`define MECS_LVL2 6'h08
`define MECS_LVL3 6'h10
`endif

//--- logic/mecs_pkg.sv
package mecs_pkg;
  // One four-channel dataset, one lane per direction.
  typedef struct packed {
    logic [15:0] north;
    logic [15:0] south;
    logic [15:0] west;
    logic [15:0] east;
  } mecs_set_s;

  // Register access from the serial interface.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mecs_req_s;

  typedef enum logic {
    MECS_AWAKE,
    MECS_ASLEEP
  } mecs_pwr_e;
endpackage : mecs_pkg

//--- logic/mecs_smoother.sv
`timescale 1ns/100ps
module mecs_smoother (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  input mecs_pkg::mecs_set_s in_data,
  input wire logic enable,
  input wire logic len4,
  output logic out_valid,
  output mecs_pkg::mecs_set_s out_data
);
  import mecs_pkg::*;

  mecs_set_s hist_q [0:2];

  // ----------------------------------------
  // Lane average
  // ----------------------------------------
  function automatic logic [15:0] avg(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
                                      input logic [15:0] d, input logic four);
    logic [17:0] s;
    s = {2'b00, a} + {2'b00, b};
    if (four)
    begin
      s = s + {2'b00, c} + {2'b00, d};
      avg = s[17:2];
    end
    else
    begin
      avg = s[16:1];
    end
  endfunction : avg

  // History restarts at each mode entry; a sample taken in the entry cycle is averaged with the old history and not kept.
  always_ff @(posedge clock)
  begin
    if (!rst_b || flush)
    begin
      hist_q[0] <= '0;
      hist_q[1] <= '0;
      hist_q[2] <= '0;
    end
    else if (in_valid)
    begin
      hist_q[0] <= in_data;
      hist_q[1] <= hist_q[0];
      hist_q[2] <= hist_q[1];
    end
  end

  // Sliding window: one result per sample, never decimated.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid && enable)
      begin
        out_data.north <= avg(in_data.north, hist_q[0].north, hist_q[1].north, hist_q[2].north, len4);
        out_data.south <= avg(in_data.south, hist_q[0].south, hist_q[1].south, hist_q[2].south, len4);
        out_data.west <= avg(in_data.west, hist_q[0].west, hist_q[1].west, hist_q[2].west, len4);
        out_data.east <= avg(in_data.east, hist_q[0].east, hist_q[1].east, hist_q[2].east, len4);
      end
      else if (in_valid)
      begin
        out_data <= in_data;
      end
    end
  end
endmodule : mecs_smoother

//--- logic/mecs_top.sv
`timescale 1ns/100ps
`include "mecs_defines.svh"
module mecs_top (
  input wire logic clock,
  input wire logic rst_b,
  input mecs_pkg::mecs_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic motion_mode_flag,
  input wire logic motion_irq_allow,
  input wire logic sleep_after_irq,
  input wire logic other_irq,
  input wire logic [5:0] buffer_count,
  input wire logic sample_valid,
  input mecs_pkg::mecs_set_s sample_data,
  input wire logic dataset_start,
  input wire logic pulse_req,
  output logic pulse_fire,
  output logic push_valid,
  output mecs_pkg::mecs_set_s push_data,
  output logic motion_irq,
  output logic osc_run
);
  import mecs_pkg::*;

  logic [7:0] pulse_fifo_q;
  logic [1:0] smooth_q;
  mecs_pwr_e pwr_q;
  logic [6:0] pulse_cnt_q;
  logic mode_q;
  logic irq_q;
  logic clr_wr;
  logic take;
  logic sm_valid;
  logic sleep_evt;
  logic [5:0] need;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic [5:0] level_need(input logic [1:0] code);
    case (code)
      2'd0: level_need = `MECS_LVL0;
      2'd1: level_need = `MECS_LVL1;
      2'd2: level_need = `MECS_LVL2;
      default: level_need = `MECS_LVL3;
    endcase
  endfunction : level_need

  assign need = level_need(pulse_fifo_q[`MECS_LVL_HI:`MECS_LVL_LO]);
  assign clr_wr = reg_req.wr && reg_req.addr == `MECS_OFS_CONTROL && reg_req.wdata[`MECS_CLR_BIT];
  assign sleep_evt = sleep_after_irq && (other_irq || (motion_irq_allow && buffer_count >= need && !irq_q));
  // Nothing is sampled while asleep; the oscillator is held off.
  assign take = sample_valid && motion_mode_flag && pwr_q == MECS_AWAKE;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      pulse_fifo_q <= `MECS_RST_PULSE_FIFO;
      smooth_q <= 2'(`MECS_RST_SMOOTH >> `MECS_SM_EN_BIT);
    end
    else if (reg_req.wr && reg_req.addr == `MECS_OFS_PULSE_FIFO)
    begin
      pulse_fifo_q <= reg_req.wdata;
    end
    else if (reg_req.wr && reg_req.addr == `MECS_OFS_SMOOTH)
    begin
      smooth_q <= reg_req.wdata[`MECS_SM_LEN_BIT:`MECS_SM_EN_BIT];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd)
      begin
        case (reg_req.addr)
          `MECS_OFS_PULSE_FIFO: reg_rdata <= pulse_fifo_q;
          `MECS_OFS_SMOOTH: reg_rdata <= {2'b00, smooth_q, 4'h0};
          `MECS_OFS_SLEEP_RPT: reg_rdata <= {6'h00, pwr_q == MECS_ASLEEP, 1'b0};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Sleep after interrupt
  // ----------------------------------------
  // A new interrupt in the clearing cycle keeps the device asleep.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      pwr_q <= MECS_AWAKE;
    end
    else
    begin
      case (pwr_q)
        MECS_AWAKE: if (sleep_evt) pwr_q <= MECS_ASLEEP;
        MECS_ASLEEP: if (clr_wr && !sleep_evt) pwr_q <= MECS_AWAKE;
        default: pwr_q <= MECS_AWAKE;
      endcase
    end
  end

  assign osc_run = pwr_q == MECS_AWAKE;

  // ----------------------------------------
  // Motion interrupt
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= motion_irq_allow && buffer_count >= need;
    end
  end

  assign motion_irq = irq_q;

  // ----------------------------------------
  // Emitter pulse limit
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_b || dataset_start)
    begin
      pulse_cnt_q <= 7'h00;
    end
    else if (pulse_fire)
    begin
      pulse_cnt_q <= pulse_cnt_q + 7'h01;
    end
  end

  // Requests beyond the limit are dropped, not deferred to the next dataset.
  assign pulse_fire = pulse_req && !dataset_start && osc_run
    && pulse_cnt_q <= {1'b0, pulse_fifo_q[`MECS_PULSE_HI:`MECS_PULSE_LO]};

  // ----------------------------------------
  // Dataset path
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      mode_q <= 1'b0;
    end
    else
    begin
      mode_q <= motion_mode_flag;
    end
  end

  mecs_smoother u_smooth (
    .clock(clock),
    .rst_b(rst_b),
    .flush(motion_mode_flag && !mode_q),
    .in_valid(take),
    .in_data(sample_data),
    .enable(smooth_q[0]),
    .len4(smooth_q[1]),
    .out_valid(sm_valid),
    .out_data(push_data)
  );

  assign push_valid = sm_valid;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_level;
    $rose(irq_q) |-> $past(buffer_count) >= level_need($past(pulse_fifo_q[7:6]));
  endproperty
  a_level: assert property (p_level) else $error("Motion interrupt below fill level.");

  property p_pulse;
    pulse_fire |-> pulse_cnt_q <= {1'b0, pulse_fifo_q[5:0]};
  endproperty
  a_pulse: assert property (p_pulse) else $error("Too many emitter pulses.");

  property p_raw;
    take && !smooth_q[0] |=> push_valid && push_data == $past(sample_data);
  endproperty
  a_raw: assert property (p_raw) else $error("Raw sample altered while smoothing off.");

  property p_avg2;
    take && smooth_q == 2'b01 |=> push_data.north == 16'(({1'b0, $past(sample_data.north)}
      + {1'b0, $past(u_smooth.hist_q[0].north)}) >> 1);
  endproperty
  a_avg2: assert property (p_avg2) else $error("Two-sample average wrong.");

  property p_every;
    take |=> push_valid;
  endproperty
  a_every: assert property (p_every) else $error("Smoothed sample not pushed.");

  property p_sleep;
    pwr_q == MECS_AWAKE && sleep_evt |=> !osc_run;
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep not entered after interrupt.");

  // The status bit must mirror the oscillator state seen when the read was taken.
  property p_flag;
    reg_rvalid && $past(reg_req.addr) == `MECS_OFS_SLEEP_RPT |-> reg_rdata[1] == !$past(osc_run);
  endproperty
  a_flag: assert property (p_flag) else $error("Sleep flag misreported.");

  property p_stay;
    pwr_q == MECS_ASLEEP && !clr_wr |=> pwr_q == MECS_ASLEEP;
  endproperty
  a_stay: assert property (p_stay) else $error("Woke without clear write.");

  property p_allow;
    !motion_irq_allow |=> !motion_irq;
  endproperty
  a_allow: assert property (p_allow) else $error("Interrupt while not allowed.");

  property p_mode;
    sample_valid && !motion_mode_flag |=> !push_valid;
  endproperty
  a_mode: assert property (p_mode) else $error("Dataset pushed outside motion mode.");

  property p_rsv;
    reg_rvalid |-> reg_rdata[7:6] == 2'b00 || $past(reg_req.addr) == 8'hb1;
  endproperty
  a_rsv: assert property (p_rsv) else $error("Reserved bits read non-zero.");

  c_irq: cover property ($rose(motion_irq));
  c_sleep_wake: cover property (pwr_q == MECS_ASLEEP ##1 pwr_q == MECS_AWAKE);
  c_avg4: cover property (take && smooth_q == 2'b11);
  c_limit: cover property (pulse_req && !pulse_fire && osc_run);
endmodule : mecs_top

//--- tb/mecs_host.sv
`timescale 1ns/100ps
module mecs_host (
  input wire logic clock,
  output mecs_pkg::mecs_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  import mecs_pkg::*;
  initial reg_req = '0;
  // -----------------------------------------
  // Single byte access, one strobe cycle
  // -----------------------------------------
  // Idle address and data are inverted so that a design latching them outside a strobe is caught.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    reg_req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge clock);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1;
    q = (wr || reg_rvalid) ? reg_rdata : 8'hxx;
  endtask : xfer
endmodule : mecs_host

//--- tb/motion_engine_config_status_tb.sv
`timescale 1ns/100ps
`include "mecs_defines.svh"
module motion_engine_config_status_tb;
  import mecs_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  mecs_req_s reg_req;
  logic [7:0] reg_rdata;
  logic [7:0] q;
  logic reg_rvalid, pulse_fire, push_valid, motion_irq, osc_run;
  logic motion_mode_flag = 1'b0;
  logic motion_irq_allow = 1'b0;
  logic sleep_after_irq = 1'b0;
  logic other_irq = 1'b0;
  logic [5:0] buffer_count = 6'h00;
  logic sample_valid = 1'b0;
  logic dataset_start = 1'b0;
  logic pulse_req = 1'b0;
  mecs_set_s sample_data = '0;
  mecs_set_s push_data;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  logic [7:0] ex [3][4] = '{'{8'h08, 8'h10, 8'h18, 8'h20}, '{8'h04, 8'h0c, 8'h14, 8'h1c},
    '{8'h02, 8'h06, 8'h0c, 8'h14}};
  logic [7:0] cfg [3] = '{8'h00, 8'h10, 8'h30};
  logic [5:0] need [4] = '{6'h01, 6'h04, 6'h08, 6'h10};
  logic [5:0] pv [3] = '{6'h00, 6'h03, 6'h3f};

  initial
  begin
    forever #2.5 clock = ~clock;
  end

  mecs_top DUT (.clock(clock), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .motion_mode_flag(motion_mode_flag), .motion_irq_allow(motion_irq_allow),
    .sleep_after_irq(sleep_after_irq), .other_irq(other_irq), .buffer_count(buffer_count),
    .sample_valid(sample_valid), .sample_data(sample_data), .dataset_start(dataset_start),
    .pulse_req(pulse_req), .pulse_fire(pulse_fire), .push_valid(push_valid), .push_data(push_data),
    .motion_irq(motion_irq), .osc_run(osc_run));

  mecs_host HOST (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // -----------------------------------------
  // Helpers
  // -----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    HOST.xfer(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    HOST.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic smp(input logic [15:0] v, input logic ev, input logic [15:0] e);
    @(posedge clock);
    sample_valid <= 1'b1;
    sample_data <= '{v, v, v, v};
    @(posedge clock);
    sample_valid <= 1'b0;
    #1;
    chk({15'h0000, push_valid}, {15'h0000, ev});
    if (ev)
    begin
      chk(push_data.north, e);
      chk(push_data.south, e);
      chk(push_data.west, e);
      chk(push_data.east, e);
    end
  endtask : smp

  task automatic irq_at(input logic [5:0] cnt, input logic e);
    @(posedge clock);
    buffer_count <= cnt;
    repeat (2) @(posedge clock);
    #1;
    chk({15'h0000, motion_irq}, {15'h0000, e});
  endtask : irq_at

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // A hang costs one mismatch and still reaches the verdict.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  // -----------------------------------------
  // Main sequence
  // -----------------------------------------
  initial
  begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    rd(`MECS_OFS_PULSE_FIFO, 8'h00);
    rd(`MECS_OFS_SMOOTH, 8'h00);
    rd(`MECS_OFS_SLEEP_RPT, 8'h00);
    rd(8'h7e, 8'h00);
    wr(`MECS_OFS_SMOOTH, 8'hff);
    rd(`MECS_OFS_SMOOTH, 8'h30);
    wr(`MECS_OFS_SLEEP_RPT, 8'hff);
    rd(`MECS_OFS_SLEEP_RPT, 8'h00);
    wr(`MECS_OFS_PULSE_FIFO, 8'hff);
    rd(`MECS_OFS_PULSE_FIFO, 8'hff);
    for (int i = 0; i < 3; i++)
    begin
      wr(`MECS_OFS_PULSE_FIFO, {2'b00, pv[i]});
      @(posedge clock);
      dataset_start <= 1'b1;
      @(posedge clock);
      dataset_start <= 1'b0;
      pulse_req <= 1'b1;
      n = 0;
      repeat (int'(pv[i]) + 3) @(negedge clock) n += int'(pulse_fire);
      @(posedge clock);
      pulse_req <= 1'b0;
      chk(16'(n), 16'(pv[i]) + 16'h0001);
    end
    motion_irq_allow <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      wr(`MECS_OFS_PULSE_FIFO, {2'(c), 6'h00});
      irq_at(need[c] - 6'h01, 1'b0);
      irq_at(need[c], 1'b1);
    end
    @(posedge clock);
    motion_irq_allow <= 1'b0;
    irq_at(6'h00, 1'b0);
    for (int m = 0; m < 3; m++)
    begin
      wr(`MECS_OFS_SMOOTH, cfg[m]);
      @(posedge clock);
      motion_mode_flag <= 1'b0;
      smp(16'h0008, 1'b0, 16'h0000);
      @(posedge clock);
      motion_mode_flag <= 1'b1;
      for (int k = 0; k < 4; k++)
        smp(16'((k + 1) * 8), 1'b1, {8'h00, ex[m][k]});
    end
    @(posedge clock);
    sleep_after_irq <= 1'b1;
    other_irq <= 1'b1;
    @(posedge clock);
    other_irq <= 1'b0;
    @(posedge clock);
    #1;
    chk({15'h0000, osc_run}, 16'h0000);
    rd(`MECS_OFS_SLEEP_RPT, 8'h02);
    smp(16'h0040, 1'b0, 16'h0000);
    // A fresh interrupt in the clearing cycle must keep the device asleep.
    @(posedge clock);
    other_irq <= 1'b1;
    wr(`MECS_OFS_CONTROL, 8'h01);
    chk({15'h0000, osc_run}, 16'h0000);
    @(posedge clock);
    other_irq <= 1'b0;
    wr(`MECS_OFS_CONTROL, 8'h01);
    @(posedge clock);
    #1;
    chk({15'h0000, osc_run}, 16'h0001);
    rd(`MECS_OFS_SLEEP_RPT, 8'h00);
    // The motion interrupt itself must also put the device to sleep.
    @(posedge clock);
    motion_irq_allow <= 1'b1;
    irq_at(6'h10, 1'b1);
    chk({15'h0000, osc_run}, 16'h0000);
    wr(`MECS_OFS_CONTROL, 8'h01);
    @(posedge clock);
    #1;
    chk({15'h0000, osc_run}, 16'h0001);
    wrap_up();
  end
endmodule : motion_engine_config_status_tb
